//--- shared/vertex_fetch_regs.svh
// Constants for the vertex fetch and draw sequencer
`ifndef VERTEX_FETCH_REGS_SVH
`define VERTEX_FETCH_REGS_SVH
// Packed word field positions, plain layout
`define VF_PX_LSB 0
`define VF_PY_LSB 10
`define VF_PZ_LSB 20
// Packed word field positions, swizzled layout
`define VF_SX_LSB 20
`define VF_SY_LSB 10
`define VF_SZ_LSB 0
`define VF_W_LSB 30
// Component count codes
`define VF_SIZE_FOUR 3'h4
`define VF_SIZE_SWZ 3'h5
// Fill and scale values
`define VF_FLOAT_ONE 32'h3f800000
`define VF_INT_ONE 32'h00000001
`define VF_Q_ONE 32'h40000000
`define VF_Q_MINUS_ONE 32'hc0000000
`define VF_SNORM10_SCALE 32'h00201008
`define VF_SNORM10_MIN 10'h200
`define VF_SNORM10_CLAMP 10'h201
`define VF_STRIDE_TIGHT 32'h00000004
// Reset values of held state
`define VF_RST_BASE 32'h00000000
`define VF_RST_STRIDE 32'h00000000
`define VF_RST_DIVISOR 32'h00000000
`define VF_RST_RESTART 32'h00000000
`endif

//--- shared/vertex_fetch_pkg.sv
// Types for the vertex fetch and draw sequencer
package vertex_fetch_pkg;
  typedef enum logic [1:0] {ATTR_FLOAT, ATTR_PACKED_U, ATTR_PACKED_S, ATTR_UINT} attr_type_t;
  typedef enum logic [1:0] {IDX_BYTE, IDX_HALF, IDX_WORD, IDX_BAD} index_width_t;
  typedef logic [3:0][31:0] attr_vec_t;
  typedef struct packed {
    logic enable;
    logic [31:0] base;
    logic [31:0] stride;
    attr_type_t atype;
    logic [2:0] size;
    logic normalize;
    logic pure_int;
    logic [31:0] divisor;
  } slot_cfg_t;
  typedef struct packed {
    logic indexed;
    logic multi;
    logic bounded;
    logic [3:0] mode;
    logic [31:0] first;
    logic [31:0] count;
    logic [31:0] instances;
    index_width_t itype;
    logic [31:0] offset;
    logic [31:0] bias;
    logic [31:0] lo;
    logic [31:0] hi;
  } draw_cmd_t;
  typedef struct packed {
    logic first_of_vertex;
    logic restart;
    logic from_memory;
    logic [3:0] slot;
    logic [31:0] inst_num;
    logic [31:0] elem;
    attr_vec_t comp;
  } vertex_rec_t;
endpackage

//--- core/vertex_fetch_draw_sequencer.sv
// Vertex fetch and draw sequencer with its output FIFO
`timescale 1ns/1ps
`default_nettype none
`include "vertex_fetch_regs.svh"

// Record FIFO, flip-flop storage
module vertex_rec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_reg, rd_reg;
  logic [AW:0] used;
  assign used = wr_reg - rd_reg;
  assign in_ready = used != (AW+1)'(DEPTH);
  assign out_valid = used != '0;
  assign out_data = mem_reg[rd_reg[AW-1:0]];
  // Pointers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else if (ce) begin
      if (in_valid && in_ready) wr_reg <= wr_reg + 1'b1;
      if (out_valid && out_ready) rd_reg <= rd_reg + 1'b1;
    end
  end
  // Storage
  always_ff @(posedge clk_sys) begin
    if (ce && in_valid && in_ready) mem_reg[wr_reg[AW-1:0]] <= in_data;
  end
endmodule

// Summary of operation
// - Unsigned packed word: three 10-bit, one 2-bit
// - Signed packed fields are two's complement
// - Normalize flag scales to unit range
// - Swizzled layout: w, x, y, z high to low
// - Linear draw fetches first..first+count-1 ascending
// - Bad kind or negative count (except multi-range linear): error, no transfer
// - Disabled required slot uses held current value
// - Held value after fetched draw is unspecified
// - Instance counter zero outside instanced iterations
// - Instanced linear repeats range per instance
// - Multi-range skips empty ranges, counter zero
// - Indexed draw reads sized indices at offset
// - Instanced indexed repeats list per instance
// - Multi-list: each list in order, counter zero
// - Bounded draw: upper below lower is error
// - Out-of-bound indices need no check
// - Bias added as wrapping 32-bit unsigned
// - Bounds compared before bias
// - Multi-list biased: per-list count, offset, bias
// - Per-slot array state plus restart index
// - Reset: slots disabled, four components, zeros
// - Missing components fill 0, 0, 1
// - Divisor zero per vertex, else per instances; multi draws always step per vertex
// - Restart index ends and restarts primitive
// - Restart compare on raw index before bias
module vertex_fetch_draw_sequencer #(
  parameter int SLOTS = 16,
  parameter int PRIM_MODES = 7,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cfg_wr_valid,
  input wire logic [3:0] cfg_wr_slot,
  input wire vertex_fetch_pkg::slot_cfg_t cfg_wr_data,
  input wire logic cur_wr_valid,
  input wire logic [3:0] cur_wr_slot,
  input wire vertex_fetch_pkg::attr_vec_t cur_wr_value,
  input wire logic restart_en,
  input wire logic restart_wr_valid,
  input wire logic [31:0] restart_wr_index,
  input wire logic [SLOTS-1:0] shader_req_mask,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire vertex_fetch_pkg::draw_cmd_t cmd_data,
  output logic idx_req_valid,
  output logic [31:0] idx_req_addr,
  input wire logic idx_rsp_valid,
  input wire logic [31:0] idx_rsp_data,
  output logic attr_req_valid,
  output logic [31:0] attr_req_addr,
  input wire logic attr_rsp_valid,
  input wire logic [31:0] attr_rsp_data,
  output logic vtx_valid,
  input wire logic vtx_ready,
  output vertex_fetch_pkg::vertex_rec_t vtx_data,
  output logic err_bad_token,
  output logic err_bad_arg,
  output logic err_out_of_bounds,
  output logic busy,
  output logic [31:0] instance_counter
);
  localparam int RW = $bits(vertex_fetch_pkg::vertex_rec_t);
  typedef enum {S_IDLE, S_CHECK, S_INDEX, S_IDXW, S_VTX, S_SLOT, S_ATTRW, S_NEXT} state_t;
  state_t state_reg;
  vertex_fetch_pkg::draw_cmd_t cmd_reg;
  vertex_fetch_pkg::slot_cfg_t slot_cfg_reg [SLOTS];
  vertex_fetch_pkg::attr_vec_t cur_val_reg [SLOTS];
  logic [31:0] inst_elem_reg [SLOTS];
  logic [31:0] step_reg [SLOTS];
  logic [31:0] restart_idx_reg, vtx_reg, inst_reg, ninst_reg, raw_reg, elem_reg;
  logic [3:0] slot_reg;
  logic first_reg, out_valid_reg;
  vertex_fetch_pkg::vertex_rec_t out_rec_reg, rec_next;
  logic push, fifo_in_ready, fifo_out_valid, pop, inst_end, last_vtx, restart_hit;
  logic [RW-1:0] fifo_out_data;
  vertex_fetch_pkg::slot_cfg_t cfg_cur;
  logic [31:0] slot_elem, idx_masked;
  logic [63:0] prod;

  // Expand one 10-bit field
  function automatic logic [31:0] conv10(input logic [9:0] v, input logic sg, input logic nrm);
    logic [9:0] s;
    s = (v == `VF_SNORM10_MIN) ? `VF_SNORM10_CLAMP : v;
    if (!nrm) conv10 = sg ? {{22{v[9]}}, v} : {22'h0, v};
    else if (!sg) conv10 = {2'b00, v, v, v} + {31'h0, &v};
    else if (s == `VF_SNORM10_CLAMP) conv10 = `VF_Q_MINUS_ONE;
    else if (s == 10'h1ff) conv10 = `VF_Q_ONE;
    else conv10 = 32'({{22{s[9]}}, s} * `VF_SNORM10_SCALE);
  endfunction

  // Expand the 2-bit w field
  function automatic logic [31:0] conv2(input logic [1:0] v, input logic sg, input logic nrm);
    if (!nrm) conv2 = sg ? {{30{v[1]}}, v} : {30'h0, v};
    else if (!sg) conv2 = {2'b00, {15{v}}} + {31'h0, &v};
    else if (v == 2'b01) conv2 = `VF_Q_ONE;
    else if (v == 2'b00) conv2 = 32'h0;
    else conv2 = `VF_Q_MINUS_ONE;
  endfunction

  // Decode one fetched word into four components
  function automatic vertex_fetch_pkg::attr_vec_t decode(
    input vertex_fetch_pkg::slot_cfg_t c, input logic [31:0] w);
    vertex_fetch_pkg::attr_vec_t r;
    logic sg, swz, nrm;
    logic [31:0] one;
    sg = c.atype == vertex_fetch_pkg::ATTR_PACKED_S;
    swz = c.size == `VF_SIZE_SWZ;
    nrm = (c.normalize || swz) && !c.pure_int;
    one = (c.atype == vertex_fetch_pkg::ATTR_FLOAT) ? `VF_FLOAT_ONE : `VF_INT_ONE;
    if (c.atype == vertex_fetch_pkg::ATTR_PACKED_U || sg) begin
      if (swz) begin
        r[0] = conv10(w[`VF_SX_LSB +: 10], sg, nrm);
        r[1] = conv10(w[`VF_SY_LSB +: 10], sg, nrm);
        r[2] = conv10(w[`VF_SZ_LSB +: 10], sg, nrm);
      end else begin
        r[0] = conv10(w[`VF_PX_LSB +: 10], sg, nrm);
        r[1] = conv10(w[`VF_PY_LSB +: 10], sg, nrm);
        r[2] = conv10(w[`VF_PZ_LSB +: 10], sg, nrm);
      end
      r[3] = conv2(w[`VF_W_LSB +: 2], sg, nrm);
    end else begin
      r[0] = w;
      r[1] = (c.size < 3'h2) ? 32'h0 : w;
      r[2] = (c.size < 3'h3) ? 32'h0 : w;
      r[3] = (c.size < `VF_SIZE_FOUR) ? one : w;
    end
    return r;
  endfunction

  // Per-slot held state and instance stepping
  genvar g;
  for (g = 0; g < SLOTS; g++) begin : g_slot
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        slot_cfg_reg[g] <= '{enable: 1'b0, base: `VF_RST_BASE, stride: `VF_RST_STRIDE,
          atype: vertex_fetch_pkg::ATTR_FLOAT, size: `VF_SIZE_FOUR, normalize: 1'b0,
          pure_int: 1'b0, divisor: `VF_RST_DIVISOR};
        cur_val_reg[g] <= '0;
        inst_elem_reg[g] <= '0;
        step_reg[g] <= '0;
      end else if (ce) begin
        if (cfg_wr_valid && cfg_wr_slot == 4'(g)) slot_cfg_reg[g] <= cfg_wr_data;
        // Held value left untouched by fetched draws
        if (cur_wr_valid && cur_wr_slot == 4'(g)) cur_val_reg[g] <= cur_wr_value;
        if (state_reg == S_CHECK) begin
          inst_elem_reg[g] <= '0;
          step_reg[g] <= '0;
        end else if (inst_end) begin
          if (step_reg[g] + 32'h1 == slot_cfg_reg[g].divisor) begin
            inst_elem_reg[g] <= inst_elem_reg[g] + 32'h1;
            step_reg[g] <= '0;
          end else begin
            step_reg[g] <= step_reg[g] + 32'h1;
          end
        end
      end
    end
  end

  // Restart index register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) restart_idx_reg <= `VF_RST_RESTART;
    else if (ce && restart_wr_valid) restart_idx_reg <= restart_wr_index;
  end

  // Element selection and address arithmetic
  always_comb begin
    cfg_cur = slot_cfg_reg[slot_reg];
    if (cmd_reg.multi || cfg_cur.divisor == 32'h0) slot_elem = elem_reg;
    else slot_elem = inst_elem_reg[slot_reg];
    prod = slot_elem * ((cfg_cur.stride == 32'h0) ? `VF_STRIDE_TIGHT : cfg_cur.stride);
    unique case (cmd_reg.itype)
      vertex_fetch_pkg::IDX_BYTE: idx_masked = {24'h0, idx_rsp_data[7:0]};
      vertex_fetch_pkg::IDX_HALF: idx_masked = {16'h0, idx_rsp_data[15:0]};
      default: idx_masked = idx_rsp_data;
    endcase
    last_vtx = vtx_reg + 32'h1 == cmd_reg.count;
    inst_end = state_reg == S_NEXT && last_vtx;
    restart_hit = restart_en && raw_reg == restart_idx_reg;
  end

  // Record assembly toward the FIFO
  always_comb begin
    rec_next = '0;
    rec_next.first_of_vertex = first_reg;
    rec_next.slot = slot_reg;
    rec_next.inst_num = instance_counter;
    rec_next.elem = slot_elem;
    push = 1'b0;
    if (state_reg == S_ATTRW && attr_rsp_valid) begin
      push = 1'b1;
      rec_next.from_memory = 1'b1;
      rec_next.comp = decode(cfg_cur, attr_rsp_data);
    end else if (state_reg == S_SLOT && !cfg_cur.enable && shader_req_mask[slot_reg]) begin
      push = fifo_in_ready;
      rec_next.comp = cur_val_reg[slot_reg];
    end else if (state_reg == S_VTX && restart_hit) begin
      push = fifo_in_ready;
      rec_next.restart = 1'b1;
    end
  end

  // Draw sequencing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      cmd_reg <= '0;
      cmd_ready <= 1'b0;
      busy <= 1'b0;
      vtx_reg <= '0;
      inst_reg <= '0;
      ninst_reg <= '0;
      raw_reg <= '0;
      elem_reg <= '0;
      slot_reg <= '0;
      first_reg <= 1'b0;
      instance_counter <= '0;
      idx_req_valid <= 1'b0;
      idx_req_addr <= '0;
      attr_req_valid <= 1'b0;
      attr_req_addr <= '0;
    end else if (ce) begin
      idx_req_valid <= 1'b0;
      attr_req_valid <= 1'b0;
      if (push) first_reg <= 1'b0;
      unique case (state_reg)
        S_IDLE: begin
          cmd_ready <= 1'b1;
          busy <= 1'b0;
          instance_counter <= '0;
          if (cmd_valid && cmd_ready) begin
            cmd_reg <= cmd_data;
            cmd_ready <= 1'b0;
            busy <= 1'b1;
            state_reg <= S_CHECK;
          end
        end
        S_CHECK: begin
          vtx_reg <= '0;
          inst_reg <= '0;
          ninst_reg <= cmd_reg.multi ? 32'h1 : cmd_reg.instances;
          // Errors and empty draws end here
          if (err_next_token() || err_next_arg() || $signed(cmd_reg.count) <= 0
              || (!cmd_reg.multi && $signed(cmd_reg.instances) <= 0)) begin
            state_reg <= S_IDLE;
          end else begin
            state_reg <= S_INDEX;
          end
        end
        S_INDEX: begin
          if (cmd_reg.indexed) begin
            idx_req_valid <= 1'b1;
            idx_req_addr <= cmd_reg.offset + (vtx_reg << cmd_reg.itype);
            state_reg <= S_IDXW;
          end else begin
            raw_reg <= cmd_reg.first + vtx_reg;
            elem_reg <= cmd_reg.first + vtx_reg;
            state_reg <= S_VTX;
          end
        end
        S_IDXW: begin
          if (idx_rsp_valid) begin
            raw_reg <= idx_masked;
            elem_reg <= idx_masked + cmd_reg.bias;
            state_reg <= S_VTX;
          end
        end
        S_VTX: begin
          slot_reg <= '0;
          first_reg <= 1'b1;
          if (!restart_hit) state_reg <= S_SLOT;
          else if (fifo_in_ready) state_reg <= S_NEXT;
        end
        S_SLOT: begin
          if (cfg_cur.enable) begin
            if (fifo_in_ready) begin
              attr_req_valid <= 1'b1;
              attr_req_addr <= cfg_cur.base + prod[31:0];
              state_reg <= S_ATTRW;
            end
          end else if (!shader_req_mask[slot_reg] || fifo_in_ready) begin
            slot_reg <= slot_reg + 4'h1;
            if (slot_reg == 4'(SLOTS - 1)) state_reg <= S_NEXT;
          end
        end
        S_ATTRW: begin
          if (attr_rsp_valid) begin
            slot_reg <= slot_reg + 4'h1;
            state_reg <= (slot_reg == 4'(SLOTS - 1)) ? S_NEXT : S_SLOT;
          end
        end
        S_NEXT: begin
          state_reg <= S_INDEX;
          vtx_reg <= vtx_reg + 32'h1;
          if (last_vtx) begin
            vtx_reg <= '0;
            inst_reg <= inst_reg + 32'h1;
            instance_counter <= inst_reg + 32'h1;
            if (inst_reg + 32'h1 == ninst_reg) begin
              instance_counter <= '0;
              state_reg <= S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Argument checks of the latched command
  function automatic logic err_next_token();
    return cmd_reg.mode >= 4'(PRIM_MODES)
      || (cmd_reg.indexed && cmd_reg.itype == vertex_fetch_pkg::IDX_BAD);
  endfunction
  function automatic logic err_next_arg();
    return ($signed(cmd_reg.count) < 0 && (cmd_reg.indexed || !cmd_reg.multi))
      || (cmd_reg.indexed && cmd_reg.bounded && cmd_reg.hi < cmd_reg.lo)
      || (!cmd_reg.multi && $signed(cmd_reg.instances) < 0);
  endfunction

  // Error pulses; bound check only flags
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_bad_token <= 1'b0;
      err_bad_arg <= 1'b0;
      err_out_of_bounds <= 1'b0;
    end else if (ce) begin
      err_bad_token <= state_reg == S_CHECK && err_next_token();
      err_bad_arg <= state_reg == S_CHECK && !err_next_token() && err_next_arg();
      err_out_of_bounds <= state_reg == S_IDXW && idx_rsp_valid && cmd_reg.bounded
        && !(restart_en && idx_masked == restart_idx_reg)
        && (idx_masked < cmd_reg.lo || idx_masked > cmd_reg.hi);
    end
  end

  vertex_rec_fifo #(.WIDTH(RW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(rec_next),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  // Registered output stage
  assign pop = !out_valid_reg || vtx_ready;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_reg <= 1'b0;
      out_rec_reg <= '0;
    end else if (ce && pop) begin
      out_valid_reg <= fifo_out_valid;
      if (fifo_out_valid) out_rec_reg <= fifo_out_data;
    end
  end
  assign vtx_valid = out_valid_reg;
  assign vtx_data = out_rec_reg;

  default clocking cb @(posedge clk_sys iff ce); endclocking
  default disable iff (!rst_n);
  idle_inst_zero_a: assert property (state_reg == S_IDLE |=> instance_counter == 32'h0)
    else $error("idle counter");
  multi_inst_zero_a: assert property (busy && cmd_reg.multi |-> instance_counter == 32'h0)
    else $error("multi counter");
  neg_count_err_a: assert property (state_reg == S_CHECK && !cmd_reg.multi
    && $signed(cmd_reg.count) < 0 && !err_next_token() |=> err_bad_arg)
    else $error("count error");
  err_no_fetch_a: assert property (err_bad_token || err_bad_arg |-> !idx_req_valid
    && !attr_req_valid ##1 state_reg == S_IDLE)
    else $error("fetch after error");
  bound_order_a: assert property (state_reg == S_CHECK && cmd_reg.indexed && cmd_reg.bounded
    && cmd_reg.hi < cmd_reg.lo && !err_next_token() |=> err_bad_arg)
    else $error("bound error");
  bias_wrap_a: assert property (state_reg == S_IDXW && idx_rsp_valid
    |=> elem_reg == raw_reg + cmd_reg.bias)
    else $error("bias element");
  linear_elem_a: assert property (state_reg == S_INDEX && !cmd_reg.indexed
    |=> elem_reg == cmd_reg.first + vtx_reg)
    else $error("linear element wrong");
  restart_emit_a: assert property (state_reg == S_VTX && restart_hit && fifo_in_ready
    |-> push && rec_next.restart ##1 state_reg == S_NEXT)
    else $error("restart record missing");
  disabled_value_a: assert property (push && !rec_next.from_memory && !rec_next.restart
    |-> rec_next.comp == cur_val_reg[slot_reg])
    else $error("held value");
  inst_cover_c: cover property (state_reg == S_NEXT && last_vtx && instance_counter != 32'h0);
  restart_cover_c: cover property (push && rec_next.restart);
  error_cover_c: cover property (err_bad_arg);
  fetch_cover_c: cover property (push && rec_next.from_memory);
endmodule
`default_nettype wire

//--- verification/vertex_mem_model.sv
// Index and attribute memory answering the sequencer's fetches
`timescale 1ns/1ps
`default_nettype none
module vertex_mem_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic idx_req_valid,
  input wire logic [31:0] idx_req_addr,
  output logic idx_rsp_valid,
  output logic [31:0] idx_rsp_data,
  input wire logic attr_req_valid,
  input wire logic [31:0] attr_req_addr,
  output logic attr_rsp_valid,
  output logic [31:0] attr_rsp_data
);
  logic [31:0] idx_mem [0:255];
  logic [31:0] attr_mem [0:255];
  logic [31:0] idx_addr, attr_addr;
  int idx_wait, attr_wait;
  // Attribute words carry their number, index words zero
  initial begin
    for (int k = 0; k < 256; k++) begin
      attr_mem[k] = {24'ha00000, k[7:0]};
      idx_mem[k] = 32'h0;
    end
  end
  // Answers after 1 or 5 cycles; idle data toggles
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {idx_wait, attr_wait} <= '0;
      {idx_rsp_valid, attr_rsp_valid, idx_rsp_data, attr_rsp_data} <= '0;
    end else begin
      idx_rsp_valid <= 1'b0;
      attr_rsp_valid <= 1'b0;
      idx_rsp_data <= ~idx_rsp_data;
      attr_rsp_data <= ~attr_rsp_data;
      if (idx_req_valid) begin
        idx_addr <= idx_req_addr;
        idx_wait <= slow ? 5 : 1;
      end else if (idx_wait == 1) begin
        idx_rsp_valid <= 1'b1;
        idx_rsp_data <= idx_mem[idx_addr[7:0]];
      end
      if (!idx_req_valid && idx_wait > 0) idx_wait <= idx_wait - 1;
      if (attr_req_valid) begin
        attr_addr <= attr_req_addr;
        attr_wait <= slow ? 5 : 1;
      end else if (attr_wait == 1) begin
        attr_rsp_valid <= 1'b1;
        attr_rsp_data <= attr_mem[attr_addr[9:2]];
      end
      if (!attr_req_valid && attr_wait > 0) attr_wait <= attr_wait - 1;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the vertex fetch and draw sequencer
`timescale 1ns/1ps
`default_nettype none
`include "vertex_fetch_regs.svh"
module tb;
  logic clk_sys, rst_n, cfg_wr_valid, cur_wr_valid, restart_en, restart_wr_valid, cmd_valid;
  logic cmd_ready, idx_req_valid, idx_rsp_valid, attr_req_valid, attr_rsp_valid, vtx_valid;
  logic vtx_ready, err_bad_token, err_bad_arg, err_out_of_bounds, busy, slow;
  logic [3:0] cfg_wr_slot, cur_wr_slot;
  logic [15:0] shader_req_mask;
  logic [31:0] restart_wr_index, idx_req_addr, idx_rsp_data, attr_req_addr, attr_rsp_data;
  logic [31:0] instance_counter;
  logic [198:0] r;
  vertex_fetch_pkg::slot_cfg_t cfg_wr_data;
  vertex_fetch_pkg::attr_vec_t cur_wr_value;
  vertex_fetch_pkg::draw_cmd_t cmd_data;
  vertex_fetch_pkg::vertex_rec_t vtx_data;
  logic [198:0] recs[$];
  int n_mismatch, n_checks, n_tok, n_arg, n_oob;
  vertex_fetch_draw_sequencer u_dut (.ce(1'b1), .*);
  vertex_mem_model u_mem (.*);
  // Clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
  // Collects records and error pulses
  always @(posedge clk_sys) begin
    if (vtx_valid === 1'b1 && vtx_ready === 1'b1) recs.push_back(vtx_data);
    if (err_bad_token === 1'b1) n_tok++;
    if (err_bad_arg === 1'b1) n_arg++;
    if (err_out_of_bounds === 1'b1) n_oob++;
  end
  task automatic check(string what, logic [198:0] seen, logic [198:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [31:0] mw(logic [31:0] a);
    return {24'ha00000, a[9:2]};
  endfunction
  function automatic logic [127:0] fl(logic [31:0] w);
    return {`VF_FLOAT_ONE, 64'h0, w};
  endfunction
  function automatic logic [198:0] pop();
    return recs.size() > 0 ? recs.pop_front() : 'x;
  endfunction
  task automatic cfg(logic [3:0] s, logic en, logic [31:0] base, logic [1:0] at,
      logic [2:0] sz, logic nm, logic pi, logic [31:0] dv);
    @(negedge clk_sys);
    cfg_wr_valid = 1'b1;
    cfg_wr_slot = s;
    cfg_wr_data = '{en, base, 32'h0, vertex_fetch_pkg::attr_type_t'(at), sz, nm, pi, dv};
    @(negedge clk_sys);
    cfg_wr_valid = 1'b0;
  endtask
  // One command, optional output stall first
  task automatic draw(logic ix, mu, bo, logic [3:0] md, logic [31:0] fi, co, inst,
      logic [1:0] it, logic [31:0] of, bi, lo, hi, int hold);
    int t;
    @(negedge clk_sys);
    cmd_data = '{ix, mu, bo, md, fi, co, inst, vertex_fetch_pkg::index_width_t'(it), of, bi, lo, hi};
    cmd_valid = 1'b1;
    @(posedge clk_sys);
    while (cmd_ready !== 1'b1) @(posedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    repeat (hold) @(negedge clk_sys);
    if (hold > 0) check("stall", {busy, vtx_valid, recs.size() == 0}, 3'b111);
    vtx_ready = 1'b1;
    for (t = 0; t < 3000 && {busy, cmd_ready, vtx_valid} !== 3'b010; t++) @(negedge clk_sys);
    check("done", t < 3000, 1'b1);
    repeat (4) @(negedge clk_sys);
  endtask
  // Idle state and held value for a disabled slot after reset
  task automatic t_held();
    check("idle", {cmd_ready, busy, instance_counter}, {2'b10, 32'h0});
    @(negedge clk_sys);
    cur_wr_valid = 1'b1;
    cur_wr_slot = 4'h3;
    cur_wr_value = {32'h4, 32'h3, 32'h2, 32'h1};
    @(negedge clk_sys);
    cur_wr_valid = 1'b0;
    shader_req_mask = 16'h0008;
    draw(0, 0, 0, 4'h0, 32'h2, 32'h1, 32'h1, 2'h0, 0, 0, 0, 0, 0);
    check("held", pop(), {3'b100, 4'h3, 32'h0, 32'h2, 32'h4, 32'h3, 32'h2, 32'h1});
  endtask
  // Linear range under output stall with a slow memory
  task automatic t_linear();
    cfg(4'h0, 1, 32'h40, 2'h0, 3'h1, 0, 0, 0);
    shader_req_mask = 16'h0009;
    slow = 1'b1;
    vtx_ready = 1'b0;
    draw(0, 0, 0, 4'h2, 32'h5, 32'h8, 32'h1, 2'h0, 0, 0, 0, 0, 150);
    slow = 1'b0;
    for (int e = 5; e < 13; e++) begin
      check("lin", pop(), {3'b101, 4'h0, 32'h0, e[31:0], fl(mw(32'h40 + 4 * e))});
      check("hld", pop(), {3'b000, 4'h3, 32'h0, e[31:0], 128'h4_00000003_00000002_00000001});
    end
  endtask
  // Mode codes 0 to 7, then argument and index type faults
  task automatic t_errors();
    for (int m = 0; m < 8; m++) begin
      n_tok = 0;
      draw(0, 0, 0, m[3:0], 32'h1, 32'h1, 32'h1, 2'h0, 0, 0, 0, 0, 0);
      check("mode", {n_tok[7:0], 8'(recs.size())}, {7'h0, m == 7, m == 7 ? 8'h0 : 8'h2});
      recs.delete();
    end
    n_arg = 0;
    draw(0, 0, 0, 4'h0, 32'h1, 32'hffffffff, 32'h1, 2'h0, 0, 0, 0, 0, 0);
    draw(1, 0, 1, 4'h0, 32'h0, 32'h1, 32'h1, 2'h0, 0, 0, 32'h5, 32'h4, 0);
    check("arg", {n_arg, 8'(recs.size())}, {32'h2, 8'h0});
    n_tok = 0;
    draw(1, 0, 1, 4'h0, 32'h0, 32'h1, 32'h1, 2'h3, 0, 0, 32'h0, 32'h4, 0);
    check("typ", {n_tok, 8'(recs.size())}, {32'h1, 8'h0});
  endtask
  task automatic pk(logic [1:0] at, logic [2:0] sz, logic nm, pi, logic [127:0] exp, msk);
    cfg(4'h0, 1, 32'h80, at, sz, nm, pi, 0);
    draw(0, 0, 0, 4'h0, 32'h0, 32'h1, 32'h1, 2'h0, 0, 0, 0, 0, 0);
    r = pop();
    check("pk", r[127:0] & msk, exp);
  endtask
  // Packed word layouts and conversions
  task automatic t_packed();
    u_mem.attr_mem[32] = 32'hbff80005;
    shader_req_mask = 16'h0001;
    pk(2'h1, 3'h4, 0, 0, {32'h2, 32'h3ff, 32'h200, 32'h5}, '1);
    pk(2'h2, 3'h4, 0, 0, {32'hfffffffe, 32'hffffffff, 32'hfffffe00, 32'h5}, '1);
    pk(2'h2, 3'h5, 0, 1, {32'hfffffffe, 32'h5, 32'hfffffe00, 32'hffffffff}, '1);
    pk(2'h1, 3'h4, 1, 0, {32'h0, `VF_Q_ONE, 64'h0}, {32'h0, 32'hffffffff, 64'h0});
    pk(2'h2, 3'h4, 1, 0, {64'h0, `VF_Q_MINUS_ONE, 32'h0}, {64'h0, 32'hffffffff, 32'h0});
    cfg(4'h0, 1, 32'h40, 2'h0, 3'h1, 0, 0, 0);
  endtask
  // Instanced range, then multi-range entries
  task automatic t_inst();
    cfg(4'h1, 1, 32'h100, 2'h0, 3'h1, 0, 0, 32'h2);
    shader_req_mask = 16'h0;
    draw(0, 0, 0, 4'h0, 32'h4, 32'h1, 32'h3, 2'h0, 0, 0, 0, 0, 0);
    for (int i = 0; i < 3; i++) begin
      r = pop();
      check("i0", {r[195:160], r[127:0]}, {4'h0, i[31:0], fl(mw(32'h50))});
      r = pop();
      check("i1", {r[195:160], r[127:0]}, {4'h1, i[31:0], fl(mw(32'h100 + 4 * (i / 2)))});
    end
    check("ctr", instance_counter, 32'h0);
    draw(0, 1, 0, 4'h0, 32'h4, 32'h0, 32'h3, 2'h0, 0, 0, 0, 0, 0);
    draw(0, 1, 0, 4'h0, 32'h3, 32'h1, 32'h3, 2'h0, 0, 0, 0, 0, 0);
    check("mr0", pop(), {3'b101, 4'h0, 32'h0, 32'h3, fl(mw(32'h4c))});
    check("mr1", pop(), {3'b001, 4'h1, 32'h0, 32'h3, fl(mw(32'h10c))});
    check("mrn", {8'(recs.size()), instance_counter}, 40'h0);
    cfg(4'h1, 0, 32'h100, 2'h0, 3'h1, 0, 0, 0);
  endtask
  // Indexed: bias, bounds, restart, lists
  task automatic t_idx();
    @(negedge clk_sys);
    {restart_en, restart_wr_valid, restart_wr_index} = {2'b11, 32'h7};
    @(negedge clk_sys);
    restart_wr_valid = 1'b0;
    {u_mem.idx_mem[16], u_mem.idx_mem[18], u_mem.idx_mem[20]} = {32'h3, 32'h7, 32'hfffe};
    u_mem.idx_mem[32] = 32'h5;
    n_oob = 0;
    draw(1, 0, 1, 4'h0, 32'h0, 32'h3, 32'h1, 2'h1, 32'h10, 32'h4, 32'h0, 32'h5, 0);
    check("b0", pop(), {3'b101, 4'h0, 32'h0, 32'h7, fl(mw(32'h5c))});
    r = pop();
    check("rs", r[197], 1'b1);
    check("b2", pop(), {3'b101, 4'h0, 32'h0, 32'h10002, fl(mw(32'h40048))});
    check("oob", n_oob, 1);
    restart_en = 1'b0;
    draw(1, 0, 0, 4'h0, 32'h0, 32'h1, 32'h2, 2'h2, 32'h20, 32'hffffffff, 0, 0, 0);
    for (int i = 0; i < 2; i++) begin
      r = pop();
      check("ii", {r[191:128], r[127:0]}, {i[31:0], 32'h4, fl(mw(32'h50))});
    end
    draw(1, 1, 0, 4'h0, 32'h0, 32'h1, 32'h2, 2'h1, 32'h10, 32'h1, 0, 0, 0);
    draw(1, 1, 0, 4'h0, 32'h0, 32'h1, 32'h2, 2'h2, 32'h20, 32'h2, 0, 0, 0);
    check("ml0", pop(), {3'b101, 4'h0, 32'h0, 32'h4, fl(mw(32'h50))});
    check("ml1", pop(), {3'b101, 4'h0, 32'h0, 32'h7, fl(mw(32'h5c))});
  endtask
  // Reset, then the scenarios in turn
  initial begin
    {rst_n, cfg_wr_valid, cur_wr_valid, restart_en, restart_wr_valid, cmd_valid, slow} = '0;
    {cfg_wr_slot, cur_wr_slot, shader_req_mask, restart_wr_index} = '0;
    {cfg_wr_data, cur_wr_value, cmd_data} = '0;
    vtx_ready = 1'b1;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    t_held();
    t_linear();
    t_errors();
    t_packed();
    t_inst();
    t_idx();
    finish_test();
  end
endmodule
`default_nettype wire
